// ### src/torque_limiter_pkg.sv
// Purpose: shared constants for the torque-mode speed window limiter
// Assumes: 25 MHz clock, values scaled 256 units per percent
// Notes: register map sits on AHB-Lite, one word per register

package torque_limiter_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int FILTER_STEP_NS = 1000000;
   localparam int FILTER_STEP_CYCLES = FILTER_STEP_NS / CLK_PERIOD_NS;

   // Fixed-point scale: one percent is 2**PCT_SHIFT units
   localparam int PCT_SHIFT = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_MARGIN = 8'h00;
   localparam logic [7:0] OFS_LIMIT = 8'h04;
   localparam logic [7:0] OFS_FILTER = 8'h08;
   localparam logic [7:0] OFS_INPUTS = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_FILTERED = 8'h14;

   // Ranges
   localparam int MARGIN_MAX = 120;
   localparam int LIMIT_MIN = -120;
   localparam int LIMIT_MAX = 120;
   localparam int FILTER_MAX = 1000;

   // Reset values
   localparam logic [6:0] MARGIN_RST = 7'h0A;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam logic [9:0] FILTER_RST = 10'h000;
   localparam logic [4:0] AUX_FUNC_RST = 5'h00;
   localparam logic [4:0] CUR_FUNC_RST = 5'h1F;
   localparam logic [4:0] CUR_FUNC_MIN = 5'h01;

   // Input function codes
   localparam logic [4:0] FUNC_TORQUE_REF = 5'h13;
   localparam logic [4:0] FUNC_TORQUE_COMP = 5'h14;

   // Field positions in the inputs register
   localparam int AUX_FUNC_LSB = 0;
   localparam int CUR_FUNC_LSB = 8;
   localparam int AUX_LVL_LSB = 16;
   localparam int CUR_LVL_LSB = 20;

   // Field positions in the status register
   localparam int STAT_OVER_BIT = 16;
   localparam int STAT_UNDER_BIT = 17;

   // Signal levels
   localparam logic [1:0] LEVEL_UNIPOLAR = 2'h0;
   localparam logic [1:0] LEVEL_BIPOLAR = 2'h1;
   localparam logic [1:0] LEVEL_CURRENT = 2'h2;
   localparam logic [1:0] AUX_LVL_RST = LEVEL_UNIPOLAR;
   localparam logic [1:0] CUR_LVL_RST = LEVEL_CURRENT;

   // Filter sequencer states
   typedef enum {F_IDLE, F_DIV, F_APPLY} filt_state_type;

endpackage

// ### src/comp_input.sv
// Purpose: conditions one analog input for torque compensation
// Assumes: raw value already scaled, signed
// Notes: one cycle latency
`timescale 1ns/1ps
`default_nettype none

module comp_input (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Analog input and its setup
   input wire logic signed [15:0] raw,
   input wire logic [1:0] level,
   input wire logic enable,
   // Compensation result
   output logic signed [15:0] comp
);

   // Sign of the input sets direction; run direction is not consulted
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         comp <= 16'sh0000;
      end else if (!enable) begin
         comp <= 16'sh0000;
      end else if (level != torque_limiter_pkg::LEVEL_BIPOLAR && raw < 0) begin
         comp <= 16'sh0000;
      end else begin
         comp <= raw;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_forward_only;
      level != torque_limiter_pkg::LEVEL_BIPOLAR |=> comp >= 0;
   endproperty
   a_forward_only: assert property (p_forward_only)
      else $error("compensation went negative on unipolar input");

   property p_follow;
      enable && level == torque_limiter_pkg::LEVEL_BIPOLAR
         |=> comp == $past(raw);
   endproperty
   a_follow: assert property (p_follow)
      else $error("compensation does not follow signed input");

endmodule // comp_input

`default_nettype wire

// ### src/lag_filter.sv
// Purpose: first-order lag on the torque reference
// Assumes: step is a one-cycle pulse each millisecond
// Notes: state kept with 16 fraction bits so small errors still settle
`timescale 1ns/1ps
`default_nettype none

module lag_filter (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Timing and setup
   input wire logic step,
   input wire logic [9:0] time_ms,
   // Data
   input wire logic signed [15:0] din,
   output logic signed [15:0] dout
);

   torque_limiter_pkg::filt_state_type state;
   logic signed [31:0] y_ext;
   logic [32:0] mag;
   logic neg;
   logic [10:0] rem;
   logic [10:0] divisor;
   logic [5:0] bit_cnt;
   logic signed [32:0] delta;
   logic [11:0] rem_sh;

   assign delta = 33'($signed({din, 16'h0000})) - 33'(y_ext);
   assign rem_sh = {rem, mag[32]};
   assign dout = y_ext[31:16];

   // Each step adds (input - state)/(T+1), divided serially in 33 cycles;
   // a step arriving mid-divide is dropped, harmless at 1 ms spacing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= torque_limiter_pkg::F_IDLE;
         y_ext <= 32'sh00000000;
         mag <= 33'h000000000;
         neg <= 1'b0;
         rem <= 11'h000;
         divisor <= 11'h000;
         bit_cnt <= 6'h00;
      end else if (time_ms == 10'h000) begin
         y_ext <= $signed({din, 16'h0000});
         state <= torque_limiter_pkg::F_IDLE;
      end else begin
         case (state)
            torque_limiter_pkg::F_IDLE: begin
               if (step) begin
                  neg <= delta[32];
                  mag <= delta[32] ? 33'(-delta) : 33'(delta);
                  rem <= 11'h000;
                  divisor <= 11'(time_ms) + 11'h001;
                  bit_cnt <= 6'h00;
                  state <= torque_limiter_pkg::F_DIV;
               end
            end
            torque_limiter_pkg::F_DIV: begin
               if (rem_sh >= {1'b0, divisor}) begin
                  rem <= 11'(rem_sh - {1'b0, divisor});
                  mag <= {mag[31:0], 1'b1};
               end else begin
                  rem <= rem_sh[10:0];
                  mag <= {mag[31:0], 1'b0};
               end
               if (bit_cnt == 6'h20) begin
                  state <= torque_limiter_pkg::F_APPLY;
               end
               bit_cnt <= bit_cnt + 6'h01;
            end
            default: begin
               y_ext <= neg ? y_ext - $signed(mag[31:0])
                            : y_ext + $signed(mag[31:0]);
               state <= torque_limiter_pkg::F_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_bypass;
      time_ms == 10'h000 |=> dout == $past(din);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("zero time constant does not pass input");

endmodule // lag_filter

`default_nettype wire

// ### src/torque_mode_speed_window_limiter.sv
// Purpose: torque-mode speed window, lag filter and compensation
// Assumes: drive quantities arrive synchronous to clk, 256 units/percent
// Notes: registers on AHB-Lite; writes outside range are ignored
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module torque_mode_speed_window_limiter #(
   parameter int STEP_CYCLES = torque_limiter_pkg::FILTER_STEP_CYCLES,
   parameter int GAIN_SHIFT = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Drive quantities
   input wire logic signed [15:0] torque_ref,
   input wire logic signed [15:0] motor_speed,
   input wire logic signed [15:0] aux_analog,
   input wire logic signed [15:0] current_analog,
   input wire logic run_reverse,
   // Results
   output logic signed [15:0] torque_out,
   output logic speed_over,
   output logic speed_under
);

   localparam int TW = $clog2(STEP_CYCLES + 1);

   // Setup registers
   logic [6:0] speed_limit_margin;
   logic signed [7:0] speed_limit_value;
   logic [9:0] torque_filter_time;
   logic [4:0] aux_input_function;
   logic [4:0] current_input_function;
   logic [1:0] aux_input_level;
   logic [1:0] current_input_level;

   // Bus state
   logic wr_pend;
   logic rd_pend;
   logic [7:0] addr;
   logic accept;
   logic [31:0] next_rdata;
   logic signed [31:0] wdata_s;

   // Datapath
   logic [TW-1:0] tick_cnt;
   logic tick;
   logic signed [15:0] filt;
   logic signed [17:0] lim_ext;
   logic signed [17:0] lim_q;
   logic signed [17:0] margin_q;
   logic signed [17:0] win_hi;
   logic signed [17:0] win_lo;
   logic signed [17:0] speed_ext;
   logic signed [17:0] total;
   logic signed [23:0] total24;
   logic signed [23:0] push_down;
   logic signed [23:0] push_up;
   logic signed [23:0] next_torque;
   logic over;
   logic under;
   logic signed [15:0] chan_raw [2];
   logic signed [15:0] chan_comp [2];
   logic [4:0] chan_func [2];
   logic [1:0] chan_level [2];

   // Clamp a wide signed value into the 16-bit output range
   function automatic logic signed [15:0] sat16(
      input logic signed [23:0] v);
      if (v > $signed(24'h007FFF)) begin
         return 16'sh7FFF;
      end else if (v < $signed(24'hFF8000)) begin
         return 16'sh8000;
      end else begin
         return v[15:0];
      end
   endfunction

   assign accept = hsel & hready & htrans[1];
   assign wdata_s = $signed(hwdata);

   // Address phase capture; holds while a read waits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= accept & hwrite;
         rd_pend <= accept & ~hwrite;
         if (accept) begin
            addr <= haddr[7:0];
         end
      end
   end

   // Reads take one wait state so a write just before is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
      end else if (accept & ~hwrite) begin
         hreadyout <= 1'b0;
      end else if (rd_pend & ~hreadyout) begin
         hreadyout <= 1'b1;
         hrdata <= next_rdata;
      end
   end

   // Every transfer answers OKAY
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Read decode; unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h00000000;
      if (addr == torque_limiter_pkg::OFS_MARGIN) begin
         next_rdata[6:0] = speed_limit_margin;
      end else if (addr == torque_limiter_pkg::OFS_LIMIT) begin
         next_rdata[7:0] = speed_limit_value;
      end else if (addr == torque_limiter_pkg::OFS_FILTER) begin
         next_rdata[9:0] = torque_filter_time;
      end else if (addr == torque_limiter_pkg::OFS_INPUTS) begin
         next_rdata[torque_limiter_pkg::AUX_FUNC_LSB +: 5] =
            aux_input_function;
         next_rdata[torque_limiter_pkg::CUR_FUNC_LSB +: 5] =
            current_input_function;
         next_rdata[torque_limiter_pkg::AUX_LVL_LSB +: 2] = aux_input_level;
         next_rdata[torque_limiter_pkg::CUR_LVL_LSB +: 2] =
            current_input_level;
      end else if (addr == torque_limiter_pkg::OFS_STATUS) begin
         next_rdata[15:0] = torque_out;
         next_rdata[torque_limiter_pkg::STAT_OVER_BIT] = speed_over;
         next_rdata[torque_limiter_pkg::STAT_UNDER_BIT] = speed_under;
      end else if (addr == torque_limiter_pkg::OFS_FILTERED) begin
         next_rdata[15:0] = filt;
      end
   end

   // Register writes in the data phase; each field except aux_input_function checked on its own
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_limit_margin <= torque_limiter_pkg::MARGIN_RST;
         speed_limit_value <= torque_limiter_pkg::LIMIT_RST;
         torque_filter_time <= torque_limiter_pkg::FILTER_RST;
         aux_input_function <= torque_limiter_pkg::AUX_FUNC_RST;
         current_input_function <= torque_limiter_pkg::CUR_FUNC_RST;
         aux_input_level <= torque_limiter_pkg::AUX_LVL_RST;
         current_input_level <= torque_limiter_pkg::CUR_LVL_RST;
      end else if (wr_pend) begin
         if (addr == torque_limiter_pkg::OFS_MARGIN) begin
            if (hwdata <= 32'(torque_limiter_pkg::MARGIN_MAX)) begin
               speed_limit_margin <= hwdata[6:0];
            end
         end else if (addr == torque_limiter_pkg::OFS_LIMIT) begin
            if (wdata_s >= torque_limiter_pkg::LIMIT_MIN &&
                wdata_s <= torque_limiter_pkg::LIMIT_MAX) begin
               speed_limit_value <= hwdata[7:0];
            end
         end else if (addr == torque_limiter_pkg::OFS_FILTER) begin
            if (hwdata <= 32'(torque_limiter_pkg::FILTER_MAX)) begin
               torque_filter_time <= hwdata[9:0];
            end
         end else if (addr == torque_limiter_pkg::OFS_INPUTS) begin
            aux_input_function <=
               hwdata[torque_limiter_pkg::AUX_FUNC_LSB +: 5];
            if (hwdata[torque_limiter_pkg::CUR_FUNC_LSB +: 5] >=
                torque_limiter_pkg::CUR_FUNC_MIN) begin
               current_input_function <=
                  hwdata[torque_limiter_pkg::CUR_FUNC_LSB +: 5];
            end
            if (hwdata[torque_limiter_pkg::AUX_LVL_LSB +: 2] <=
                torque_limiter_pkg::LEVEL_BIPOLAR) begin
               aux_input_level <=
                  hwdata[torque_limiter_pkg::AUX_LVL_LSB +: 2];
            end
            if (hwdata[torque_limiter_pkg::CUR_LVL_LSB +: 2] <=
                torque_limiter_pkg::LEVEL_CURRENT) begin
               current_input_level <=
                  hwdata[torque_limiter_pkg::CUR_LVL_LSB +: 2];
            end
         end
      end
   end

   // Millisecond step for the filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TW'(STEP_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + TW'(1);
         tick <= 1'b0;
      end
   end

   lag_filter u_filter (
      .clk(clk),
      .rst(rst),
      .step(tick),
      .time_ms(torque_filter_time),
      .din(torque_ref),
      .dout(filt)
   );

   // Both analog inputs may carry compensation
   assign chan_raw[0] = aux_analog;
   assign chan_raw[1] = current_analog;
   assign chan_func[0] = aux_input_function;
   assign chan_func[1] = current_input_function;
   assign chan_level[0] = aux_input_level;
   assign chan_level[1] = current_input_level;

   for (genvar c = 0; c < 2; c++) begin : g_comp
      comp_input u_comp (
         .clk(clk),
         .rst(rst),
         .raw(chan_raw[c]),
         .level(chan_level[c]),
         .enable(chan_func[c] == torque_limiter_pkg::FUNC_TORQUE_COMP),
         .comp(chan_comp[c])
      );
   end

   // Common scale: percent settings shifted up to speed units
   assign lim_ext = 18'(speed_limit_value);
   assign lim_q = (run_reverse ? -lim_ext : lim_ext) <<<
      torque_limiter_pkg::PCT_SHIFT;
   assign margin_q = $signed({3'h0, speed_limit_margin, 8'h00});
   assign speed_ext = 18'(motor_speed);

   // Window edges; the unlimited side keeps only the margin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         win_hi <= 18'sh00000;
         win_lo <= 18'sh00000;
      end else if (lim_q >= 0) begin
         win_hi <= lim_q + margin_q;
         win_lo <= -margin_q;
      end else begin
         win_hi <= margin_q;
         win_lo <= lim_q - margin_q;
      end
   end

   // Filtered reference plus compensation
   assign total = 18'(filt) + 18'(chan_comp[0]) + 18'(chan_comp[1]);
   assign total24 = 24'(total);
   assign over = speed_ext > win_hi;
   assign under = speed_ext < win_lo;
   assign push_down = 24'(speed_ext - win_hi) <<< GAIN_SHIFT;
   assign push_up = 24'(win_lo - speed_ext) <<< GAIN_SHIFT;

   // Correction grows with overshoot but never lets the sign flip back
   always_comb begin
      next_torque = total24;
      if (over) begin
         next_torque = total24 - push_down;
         if (next_torque >= 0) begin
            next_torque = $signed(24'hFFFFFF);
         end
      end else if (under) begin
         next_torque = total24 + push_up;
         if (next_torque <= 0) begin
            next_torque = $signed(24'h000001);
         end
      end
   end

   // Registered results
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         torque_out <= 16'sh0000;
         speed_over <= 1'b0;
         speed_under <= 1'b0;
      end else begin
         torque_out <= sat16(next_torque);
         speed_over <= over;
         speed_under <= under;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_margin_keep;
      wr_pend && addr == torque_limiter_pkg::OFS_MARGIN &&
         hwdata > 32'h00000078 |=> $stable(speed_limit_margin);
   endproperty
   a_margin_keep: assert property (p_margin_keep)
      else $error("out of range margin was stored");

   property p_window;
      lim_q >= 0 |=> win_hi == $past(lim_q) + $past(margin_q) &&
         win_lo == -$past(margin_q);
   endproperty
   a_window: assert property (p_window)
      else $error("window edges wrong");

   property p_pass;
      !over && !under |=> torque_out == $past(sat16(total24));
   endproperty
   a_pass: assert property (p_pass)
      else $error("torque altered inside window");

   property p_over_neg;
      over |=> torque_out < 0 && speed_over;
   endproperty
   a_over_neg: assert property (p_over_neg)
      else $error("torque not negative above window");

   property p_under_pos;
      under |=> torque_out > 0 && speed_under;
   endproperty
   a_under_pos: assert property (p_under_pos)
      else $error("torque not positive below window");

   property p_cur_func;
      current_input_function != 5'h00;
   endproperty
   a_cur_func: assert property (p_cur_func)
      else $error("current input function code zero");

   property p_levels;
      aux_input_level <= torque_limiter_pkg::LEVEL_BIPOLAR &&
         current_input_level <= torque_limiter_pkg::LEVEL_CURRENT;
   endproperty
   a_levels: assert property (p_levels)
      else $error("illegal signal level held");

   property p_reverse;
      speed_limit_value > 0 && run_reverse |=> win_hi == $past(margin_q);
   endproperty
   a_reverse: assert property (p_reverse)
      else $error("reverse run did not mirror limit");

endmodule // torque_mode_speed_window_limiter

`default_nettype wire

// ### dv/host_ref_model.sv
// Purpose: host controller driving torque, speed and analog references
// Assumes: values already scaled 256 units per percent
// Notes: every update lands by non-blocking assignment after a rising edge
`timescale 1ns/1ps
`default_nettype none

module host_ref_model (
   // Clock
   input wire logic clk,
   // Drive quantities towards the limiter
   output logic signed [15:0] torque_ref,
   output logic signed [15:0] motor_speed,
   output logic signed [15:0] aux_analog,
   output logic signed [15:0] current_analog,
   output logic run_reverse
);
   // Quiet references until the bench asks for a value
   initial begin
      torque_ref = 16'sh0000;
      motor_speed = 16'sh0000;
      aux_analog = 16'sh0000;
      current_analog = 16'sh0000;
      run_reverse = 1'b0;
   end

   // Sign is kept, so the direction of compensation rides on it
   task automatic apply(input int t, s, a, c, input bit r);
      @(posedge clk);
      torque_ref <= 16'(t);
      motor_speed <= 16'(s);
      aux_analog <= 16'(a);
      current_analog <= 16'(c);
      run_reverse <= r;
   endtask
endmodule // host_ref_model
`default_nettype wire

// ### dv/tb_torque_mode_speed_window_limiter.sv
// Purpose: self-checking bench for the speed window limiter
// Assumes: filter tick shortened to 40 cycles
// Notes: an integer model recomputes torque and flags for every case
`timescale 1ns/1ps
`default_nettype none

module tb_torque_mode_speed_window_limiter;
   logic clk, rst, hsel, hwrite, rdy, resp, over, under, rev;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic signed [15:0] tq, sp, ax, cu, tout;
   int err_count, compares, mg, lim, af, al, cf, cl, i;
   int exp_q[$];

   torque_mode_speed_window_limiter #(
      .STEP_CYCLES(40)
   ) i_torque_mode_speed_window_limiter (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
      .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .torque_ref(tq),
      .motor_speed(sp), .aux_analog(ax), .current_analog(cu),
      .run_reverse(rev), .torque_out(tout), .speed_over(over),
      .speed_under(under));

   host_ref_model i_host_ref_model (.clk(clk), .torque_ref(tq),
      .motor_speed(sp), .aux_analog(ax), .current_analog(cu),
      .run_reverse(rev));

   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single word transfer; waits on hready, only the watchdog ends it
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = hrdata;
      if (resp !== 1'b0) chk(32'h1, 32'h0);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // Software only gives compensation to a non torque-reference input
   task automatic cfg(int m, l, a_f, a_l, c_f, c_l);
      reg_wr(8'h00, m);
      reg_wr(8'h04, l);
      reg_wr(8'h0C, a_f | c_f << 8 | a_l << 16 | c_l << 20);
      mg = m;
      lim = l;
      af = a_f;
      al = a_l;
      cf = c_f;
      cl = c_l;
   endtask

   function automatic int cmp(int v, f, l);
      if (f != 32'h14) return 0;
      return (l != 1 && v < 0) ? 0 : v;
   endfunction

   function automatic int model(input int t, s, a, c, input bit r,
                                output bit ov, un);
      int lv, lo, hi, tot;
      lv = r ? -lim * 256 : lim * 256;
      lo = lv >= 0 ? -mg * 256 : lv - mg * 256;
      hi = lv >= 0 ? lv + mg * 256 : mg * 256;
      tot = t + cmp(a, af, al) + cmp(c, cf, cl);
      ov = s > hi;
      un = s < lo;
      if (ov) tot = tot - (s - hi) * 4 >= 0 ? -1 : tot - (s - hi) * 4;
      if (un) tot = tot + (lo - s) * 4 <= 0 ? 1 : tot + (lo - s) * 4;
      return tot > 32767 ? 32767 : (tot < -32768 ? -32768 : tot);
   endfunction

   // Inputs held still; comp path settles within two cycles
   task automatic run_case(int t, s, a, c, bit r);
      int e;
      bit ov, un;
      i_host_ref_model.apply(t, s, a, c, r);
      e = model(t, s, a, c, r, ov, un);
      exp_q.push_back(e);
      repeat (4) @(posedge clk);
      e = exp_q.pop_front();
      chk({{16{tout[15]}}, tout}, e);
      chk({30'h0, over, under}, {30'h0, ov, un});
      reg_rd(8'h10, {14'h0, un, ov, 16'(e)});
   endtask

   // Main sequence
   initial begin
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      rst = 1'b1;
      err_count = 0;
      compares = 0;
      void'($urandom(3088));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_rd(8'h00, 32'h0000000A);
      reg_rd(8'h04, 32'h0);
      reg_rd(8'h08, 32'h0);
      reg_rd(8'h0C, 32'h00201F00);
      reg_rd(8'h18, 32'h0);
      // Out-of-range values must leave the fields alone
      reg_wr(8'h00, 121);
      reg_wr(8'h04, -121);
      reg_wr(8'h08, 1001);
      reg_wr(8'h0C, 32'h00320014);
      reg_rd(8'h00, 32'h0000000A);
      reg_rd(8'h04, 32'h0);
      reg_rd(8'h08, 32'h0);
      reg_rd(8'h0C, 32'h00201F14);
      reg_wr(8'h00, 120);
      reg_rd(8'h00, 32'h78);
      reg_wr(8'h04, -120);
      reg_rd(8'h04, 32'h88);
      reg_wr(8'h08, 1000);
      reg_rd(8'h08, 32'h3E8);
      reg_wr(8'h08, 0);
      cfg(10, 50, 0, 0, 32'h1F, 2);
      run_case(1000, 0, 0, 0, 0);
      run_case(1000, 15360, 0, 0, 0);
      run_case(1000, 16360, 0, 0, 0);
      run_case(1000, -2560, 0, 0, 0);
      run_case(1000, -2561, 0, 0, 0);
      run_case(1000, 3000, 0, 0, 1);
      cfg(10, 50, 32'h14, 1, 32'h14, 2);
      run_case(500, 0, -300, -300, 0);
      cfg(10, 50, 32'h14, 0, 32'h14, 1);
      run_case(500, 0, -300, -200, 1);
      for (i = 0; i < 30; i++) begin
         cfg($urandom_range(120), int'($urandom_range(240)) - 120,
             $urandom_range(1) * 32'h14, $urandom_range(1),
             $urandom_range(1) ? 32'h14 : 32'h1F, $urandom_range(2));
         run_case(int'($urandom_range(8000)) - 4000,
                  int'($urandom_range(64000)) - 32000,
                  int'($urandom_range(8000)) - 4000,
                  int'($urandom_range(8000)) - 4000,
                  $urandom_range(1));
      end
      // Lag of four ticks: partway after two ticks, settled after sixty
      cfg(120, 120, 0, 0, 32'h1F, 2);
      run_case(0, 0, 0, 0, 0);
      reg_wr(8'h08, 3);
      i_host_ref_model.apply(4096, 0, 0, 0, 0);
      repeat (80) @(posedge clk);
      chk({31'h0, tout > 0 && tout < 4096}, 32'h1);
      repeat (2400) @(posedge clk);
      chk({31'h0, tout > 4093 && tout <= 4096}, 32'h1);
      bus(1'b0, 8'h14, 32'h0, q);
      chk({31'h0, q > 32'h00000FFD && q <= 32'h00001000}, 32'h1);
      print_verdict;
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 20000);
      err_count++;
      print_verdict;
   end
endmodule // tb_torque_mode_speed_window_limiter
`default_nettype wire
